// ### tmc_mode_ctrl.sv
// transmitter mode controller top: modes, interlocks, mute, cutback
// Function
// R1: only operate and standby; mute within operate
// R2: low remote operate line requests operate
// R3: operate menu selection requests operate
// R4: serial operate command requests operate
// R5: heat-sink above 78 C blocks operate
// R6: any mute condition blocks operate entry
// R7: amplifier interlock high blocks operate
// R8: remote standby active or fault blocks operate
// R9: operate faults assert mute, stay operate
// R10: mute keeps supply on, IF muted
// R11: operate enables IF, supply, indicators
// R12: standby disables IF, supply, indicators
// R13: low remote standby line requests standby
// R14: standby menu key requests standby
// R15: serial standby command requests standby
// R16: input loss cuts power, lights fault
// R17: input return restores power, clears fault
// R18: channels 14..83 map to 6 MHz bands
// R19: custom frequency may replace channel
// R20: amplifier stays enabled through mute
// R21: reset to standby; standby wins ties
// R22: requests are edge events
`timescale 1ns/1ps
module tmc_mode_ctrl (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        rmtOperate_n,
    input  wire logic        rmtStandby_n,
    input  wire logic        operate_menu_selection,
    input  wire logic        standby_menu_key,
    input  wire logic        serialOperateCmd,
    input  wire logic        serialStandbyCmd,
    input  wire logic [7:0]  heatSinkTempC,
    input  wire logic        ampInterlock,
    input  wire logic        upconvUnlocked,
    input  wire logic        upconvAbsent,
    input  wire logic        ifStageAbsent,
    input  wire logic        modulatorMute,
    input  wire logic        otherFault,
    input  wire logic        inputPresent,
    input  wire logic [3:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [31:0]      regRdata,
    output logic             ifEnable,
    output logic             ifMute,
    output logic             supplyEnable,
    output logic             powerCutback,
    output logic             ledOperate,
    output logic             ledMuteRed,
    output logic             ledAmpEnable,
    output logic             ledInputFault,
    output logic             rmtStateOut_n
);
    tmc_pkg::tmc_mode_t mode_q;
    tmc_pkg::tmc_mode_t mode_d;
    tmc_req_if          req ();
    logic               swOperate;
    logic               swStandby;
    logic               evOpRmt;
    logic               evOpMenu;
    logic               evOpSer;
    logic               evOpSw;
    logic               evSbRmt;
    logic               evSbMenu;
    logic               evSbSer;
    logic               evSbSw;
    logic               muteCond;
    logic               overTemp;
    logic               entryBlocked;
    logic [6:0]         channel_q;
    logic               useCustom_q;
    logic [11:0]        customMhz_q;
    logic [11:0]        freqMhz;
    logic               chanValid;
    logic               cutback_q;
    logic [31:0]        rdata_q;
    logic               inOperate;

    // software pulses from the control register
    assign swOperate = regWr && (regAddr == tmc_pkg::ADDR_CTRL) &&
                       regWdata[tmc_pkg::CTRL_OPERATE_BIT]; // R4
    assign swStandby = regWr && (regAddr == tmc_pkg::ADDR_CTRL) &&
                       regWdata[tmc_pkg::CTRL_STANDBY_BIT]; // R15

    tmc_edge_det uOpRmt (.clk(clk), .sys_rst(sys_rst),
        .level(~rmtOperate_n), .pulse(evOpRmt)); // R2 R22
    tmc_edge_det uOpMenu (.clk(clk), .sys_rst(sys_rst),
        .level(operate_menu_selection), .pulse(evOpMenu)); // R3 R22
    tmc_edge_det uOpSer (.clk(clk), .sys_rst(sys_rst),
        .level(serialOperateCmd), .pulse(evOpSer)); // R4 R22
    tmc_edge_det uOpSw (.clk(clk), .sys_rst(sys_rst),
        .level(swOperate), .pulse(evOpSw));
    tmc_edge_det uSbRmt (.clk(clk), .sys_rst(sys_rst),
        .level(~rmtStandby_n), .pulse(evSbRmt)); // R13 R22
    tmc_edge_det uSbMenu (.clk(clk), .sys_rst(sys_rst),
        .level(standby_menu_key), .pulse(evSbMenu)); // R14 R22
    tmc_edge_det uSbSer (.clk(clk), .sys_rst(sys_rst),
        .level(serialStandbyCmd), .pulse(evSbSer)); // R15 R22
    tmc_edge_det uSbSw (.clk(clk), .sys_rst(sys_rst),
        .level(swStandby), .pulse(evSbSw));

    assign req.operateEvt = evOpRmt | evOpMenu | evOpSer | evOpSw;
    assign req.standbyEvt = evSbRmt | evSbMenu | evSbSer | evSbSw;

    assign muteCond = upconvUnlocked | upconvAbsent | ifStageAbsent |
                      modulatorMute; // R9
    assign overTemp = heatSinkTempC > tmc_pkg::TEMP_LIMIT_C; // R5
    assign entryBlocked = overTemp // R5
                        | muteCond // R6
                        | ampInterlock // R7
                        | ~rmtStandby_n | otherFault; // R8

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            tmc_pkg::TMC_STANDBY: begin
                if (req.operateEvt && !req.standbyEvt && !entryBlocked) begin
                    mode_d = tmc_pkg::TMC_OPERATE; // R2 R3 R4
                end
            end
            tmc_pkg::TMC_OPERATE: begin
                // mute does not leave operate
                if (req.standbyEvt) begin
                    mode_d = tmc_pkg::TMC_STANDBY; // R13 R14 R15 R21
                end
            end
            default: begin
                mode_d = tmc_pkg::TMC_STANDBY; // R1
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_q <= tmc_pkg::TMC_STANDBY; // R21
        end else begin
            mode_q <= mode_d; // R1
        end
    end

    // input loss cutback follows the signal both ways
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cutback_q <= 1'b0;
        end else begin
            cutback_q <= ~inputPresent; // R16 R17
        end
    end

    // frequency setup registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            channel_q   <= tmc_pkg::CH_RESET;
            useCustom_q <= 1'b0;
            customMhz_q <= tmc_pkg::CUSTOM_RESET;
        end else if (regWr) begin
            if (regAddr == tmc_pkg::ADDR_CHANNEL &&
                regWdata[6:0] >= tmc_pkg::CH_FIRST &&
                regWdata[6:0] <= tmc_pkg::CH_LAST) begin
                channel_q <= regWdata[6:0]; // R18
            end
            if (regAddr == tmc_pkg::ADDR_CUSTOM) begin
                customMhz_q <= regWdata[11:0]; // R19
            end
            if (regAddr == tmc_pkg::ADDR_CTRL) begin
                useCustom_q <= regWdata[tmc_pkg::CTRL_CUSTOM_BIT]; // R19
            end
        end
    end

    tmc_freq_map uFreq (
        .channel   (channel_q),
        .useCustom (useCustom_q),
        .customMhz (customMhz_q),
        .freqMhz   (freqMhz),
        .chanValid (chanValid)
    ); // R18 R19

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (regRd) begin
            case (regAddr)
                tmc_pkg::ADDR_CTRL:
                    rdata_q <= {29'h0, useCustom_q, 2'h0};
                tmc_pkg::ADDR_STATUS:
                    rdata_q <= {24'h0, overTemp, chanValid, cutback_q,
                                muteCond, entryBlocked, 1'b0, mode_q};
                tmc_pkg::ADDR_CHANNEL:
                    rdata_q <= {25'h0, channel_q};
                tmc_pkg::ADDR_CUSTOM:
                    rdata_q <= {20'h0, customMhz_q};
                tmc_pkg::ADDR_FREQ:
                    rdata_q <= {20'h0, freqMhz};
                default:
                    rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end
    assign regRdata = rdata_q;

    assign inOperate = (mode_q == tmc_pkg::TMC_OPERATE);

    // output stage: all registered
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ifEnable      <= 1'b0;
            ifMute        <= 1'b0;
            supplyEnable  <= 1'b0;
            powerCutback  <= 1'b0;
            ledOperate    <= 1'b0;
            ledMuteRed    <= 1'b1;
            ledAmpEnable  <= 1'b0;
            ledInputFault <= 1'b0;
            rmtStateOut_n <= 1'b1;
        end else begin
            ifEnable      <= inOperate; // R11 R12
            ifMute        <= inOperate & muteCond; // R10
            supplyEnable  <= inOperate; // R10 R11 R12
            powerCutback  <= inOperate & ~inputPresent; // R16 R17
            ledOperate    <= inOperate; // R11 R12
            ledMuteRed    <= ~inOperate | muteCond; // R11 R12
            ledAmpEnable  <= inOperate; // R20 R11 R12
            ledInputFault <= ~inputPresent; // R16 R17
            rmtStateOut_n <= ~inOperate;
        end
    end

    sequence opReq_s;
        req.operateEvt && !req.standbyEvt;
    endsequence

    sequence clearPath_s;
        !entryBlocked && mode_q == tmc_pkg::TMC_STANDBY;
    endsequence

    sequence stbyOuts_s;
        !ifEnable && !supplyEnable && !ifMute && ledMuteRed && !ledOperate
        && !ledAmpEnable && rmtStateOut_n;
    endsequence

    mode_onehot_a: assert property ( // R1
        @(posedge clk) disable iff (sys_rst)
        $onehot(mode_q))
        else $error("mode not one-hot");
    mode_enter_a: assert property ( // R2
        @(posedge clk) disable iff (sys_rst)
        (opReq_s and clearPath_s) |=> ##1 (ifEnable && supplyEnable))
        else $error("operate not entered");

    // a fresh edge on any source becomes a request event
    rmt_op_a: assert property ( // R2 R22
        @(posedge clk) disable iff (sys_rst)
        (!$past(sys_rst) && $fell(rmtOperate_n)) |->
        req.operateEvt)
        else $error("remote operate edge lost");
    menu_op_a: assert property ( // R3 R22
        @(posedge clk) disable iff (sys_rst)
        (!$past(sys_rst) && $rose(operate_menu_selection)) |->
        req.operateEvt)
        else $error("menu operate edge lost");
    ser_op_a: assert property ( // R4 R22
        @(posedge clk) disable iff (sys_rst)
        (!$past(sys_rst) && $rose(serialOperateCmd)) |->
        req.operateEvt)
        else $error("serial operate edge lost");
    rmt_sb_a: assert property ( // R13 R22
        @(posedge clk) disable iff (sys_rst)
        (!$past(sys_rst) && $fell(rmtStandby_n)) |->
        req.standbyEvt)
        else $error("remote standby edge lost");
    menu_sb_a: assert property ( // R14 R22
        @(posedge clk) disable iff (sys_rst)
        (!$past(sys_rst) && $rose(standby_menu_key)) |->
        req.standbyEvt)
        else $error("standby key edge lost");
    ser_sb_a: assert property ( // R15 R22
        @(posedge clk) disable iff (sys_rst)
        (!$past(sys_rst) && $rose(serialStandbyCmd)) |->
        req.standbyEvt)
        else $error("serial standby edge lost");
    held_line_a: assert property ( // R22
        @(posedge clk) disable iff (sys_rst)
        (!rmtOperate_n && !$past(rmtOperate_n) && !evOpMenu && !evOpSer
         && !evOpSw) |-> !req.operateEvt)
        else $error("held line retriggers");

    // interlocks keep the controller in standby
    temp_block_a: assert property ( // R5
        @(posedge clk) disable iff (sys_rst)
        (mode_q == tmc_pkg::TMC_STANDBY && overTemp) |=>
        mode_q == tmc_pkg::TMC_STANDBY)
        else $error("entered operate when hot");
    mute_block_a: assert property ( // R6
        @(posedge clk) disable iff (sys_rst)
        (mode_q == tmc_pkg::TMC_STANDBY && muteCond) |=>
        mode_q == tmc_pkg::TMC_STANDBY)
        else $error("entered operate while muted");
    amp_block_a: assert property ( // R7
        @(posedge clk) disable iff (sys_rst)
        (mode_q == tmc_pkg::TMC_STANDBY && ampInterlock) |=>
        mode_q == tmc_pkg::TMC_STANDBY)
        else $error("entered operate without amplifier");
    sb_block_a: assert property ( // R8
        @(posedge clk) disable iff (sys_rst)
        (mode_q == tmc_pkg::TMC_STANDBY && (!rmtStandby_n || otherFault))
        |=> mode_q == tmc_pkg::TMC_STANDBY)
        else $error("entered operate against standby or fault");

    // output stage per mode
    mute_stay_a: assert property ( // R9
        @(posedge clk) disable iff (sys_rst)
        (inOperate && muteCond && !req.standbyEvt) |=>
        (inOperate && ifMute && supplyEnable && ledAmpEnable))
        else $error("mute handling wrong");
    mute_supply_a: assert property ( // R10 R20
        @(posedge clk) disable iff (sys_rst)
        ifMute |-> (ifEnable && supplyEnable && ledAmpEnable))
        else $error("supply dropped during mute");
    oper_outs_a: assert property ( // R11
        @(posedge clk) disable iff (sys_rst)
        (inOperate && !muteCond) |=> (ifEnable && supplyEnable && ledOperate
        && ledAmpEnable && !ledMuteRed && !rmtStateOut_n))
        else $error("operate outputs wrong");
    stby_outs_a: assert property ( // R12
        @(posedge clk) disable iff (sys_rst)
        !inOperate |=> stbyOuts_s)
        else $error("standby outputs wrong");
    standby_win_a: assert property ( // R21
        @(posedge clk) disable iff (sys_rst)
        req.standbyEvt |=> mode_q == tmc_pkg::TMC_STANDBY ##1 stbyOuts_s)
        else $error("standby not taken");
    input_cut_a: assert property ( // R16
        @(posedge clk) disable iff (sys_rst)
        (inOperate && !inputPresent) |=> (powerCutback && ledInputFault))
        else $error("no cutback on input loss");
    input_led_a: assert property ( // R16
        @(posedge clk) disable iff (sys_rst)
        !inputPresent |=> ledInputFault)
        else $error("input fault indicator dark");
    power_restore_a: assert property ( // R17
        @(posedge clk) disable iff (sys_rst)
        inputPresent |=> (!powerCutback && !ledInputFault))
        else $error("power not restored");
    custom_freq_a: assert property ( // R19
        @(posedge clk) disable iff (sys_rst)
        useCustom_q |-> freqMhz == customMhz_q)
        else $error("custom frequency not selected");
endmodule

// ### tmc_pkg.sv
// package of constants for the transmitter mode controller
package tmc_pkg;
    // top-level modes, one-hot
    typedef enum logic [1:0] {
        TMC_STANDBY = 2'h1,
        TMC_OPERATE = 2'h2
    } tmc_mode_t;

    // register port word offsets
    localparam logic [3:0] ADDR_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_STATUS  = 4'h1;
    localparam logic [3:0] ADDR_CHANNEL = 4'h2;
    localparam logic [3:0] ADDR_CUSTOM  = 4'h3;
    localparam logic [3:0] ADDR_FREQ    = 4'h4;

    // control register fields (write 1 to pulse operate or standby; the custom bit is held)
    localparam int CTRL_OPERATE_BIT = 0;
    localparam int CTRL_STANDBY_BIT = 1;
    localparam int CTRL_CUSTOM_BIT  = 2;

    // heat-sink limit in degrees C
    localparam logic [7:0] TEMP_LIMIT_C = 8'h4E;

    // channel plan
    localparam logic [6:0]  CH_FIRST     = 7'h0E;
    localparam logic [6:0]  CH_LAST      = 7'h53;
    localparam logic [11:0] CH_BASE_MHZ  = 12'h1D6;
    localparam logic [11:0] CH_STEP_MHZ  = 12'h006;
    localparam logic [6:0]  CH_RESET     = 7'h0E;
    localparam logic [11:0] CUSTOM_RESET = 12'h1D6;
endpackage

// ### tmc_req_if.sv
// interface carrying request edge events to the mode core
`timescale 1ns/1ps
interface tmc_req_if;
    logic operateEvt;
    logic standbyEvt;
    modport src  (output operateEvt, output standbyEvt);
    modport sink (input operateEvt, input standbyEvt);
endinterface

// ### tmc_edge_det.sv
// rising-edge detector for one request line
`timescale 1ns/1ps
module tmc_edge_det (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic level,
    output logic      pulse
);
    logic prev_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= level;
        end
    end

    assign pulse = level & ~prev_q;
endmodule

// ### tmc_freq_map.sv
// channel to output band lower edge, or custom frequency
`timescale 1ns/1ps
module tmc_freq_map (
    input  wire logic [6:0]  channel,
    input  wire logic        useCustom,
    input  wire logic [11:0] customMhz,
    output logic [11:0]      freqMhz,
    output logic             chanValid
);
    logic [11:0] offs;

    always_comb begin
        offs = 12'({5'h00, channel - tmc_pkg::CH_FIRST}) *
               tmc_pkg::CH_STEP_MHZ;
        chanValid = (channel >= tmc_pkg::CH_FIRST) &&
                    (channel <= tmc_pkg::CH_LAST);
        if (useCustom) begin
            freqMhz = customMhz;
        end else begin
            freqMhz = tmc_pkg::CH_BASE_MHZ + offs;
        end
    end
endmodule

// ### tmc_panel_model.sv
// remote terminal block, front panel and serial host request sources
`timescale 1ns/1ps
module tmc_panel_model (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       fireOp,
    input  wire logic       fireSb,
    input  wire logic [1:0] src,
    input  wire logic       holdSb,
    output logic            rmtOperate_n,
    output logic            rmtStandby_n,
    output logic            menuOp,
    output logic            stbKey,
    output logic            serOp,
    output logic            serSb
);
    logic [1:0] opCnt_q;
    logic [1:0] sbCnt_q;
    logic       opOn;
    logic       sbOn;

    // each request stands three cycles, then the line goes idle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            opCnt_q <= 2'h0;
            sbCnt_q <= 2'h0;
        end else begin
            opCnt_q <= fireOp ? 2'h3 : opCnt_q - (opCnt_q != 2'h0);
            sbCnt_q <= fireSb ? 2'h3 : sbCnt_q - (sbCnt_q != 2'h0);
        end
    end
    assign opOn = (opCnt_q != 2'h0);
    assign sbOn = (sbCnt_q != 2'h0);
    // remote lines are pulled up when nothing pulls them down
    assign rmtOperate_n = !(opOn && src == 2'h0);
    assign rmtStandby_n = !((sbOn && src == 2'h0) || holdSb);
    assign menuOp = opOn && src == 2'h1;
    assign stbKey = sbOn && src == 2'h1;
    assign serOp  = opOn && src == 2'h2;
    assign serSb  = sbOn && src == 2'h2;
endmodule

// ### transmitter_mode_controller_bench.sv
// self-checking bench for the transmitter mode controller
`timescale 1ns/1ps
module transmitter_mode_controller_bench;
    // {ifEn,ifMute,supply,cutback,ledOp,ledMute,ledAmp,ledInFault,state_n}
    localparam logic [8:0] STBY = 9'h009;
    localparam logic [8:0] OPER = 9'h154;
    localparam logic [8:0] MUTD = 9'h1DC;
    localparam logic [8:0] CUTB = 9'h176;
    logic        clk = 1'b0;
    logic        sysRst = 1'b1;
    logic        fireOp = 1'b0;
    logic        fireSb = 1'b0;
    logic [1:0]  src = 2'h0;
    logic        holdSb = 1'b0;
    logic [7:0]  temp = 8'h19;
    logic        amp = 1'b0;
    logic [3:0]  muteV = 4'h0;
    logic        fault = 1'b0;
    logic        inPres = 1'b1;
    logic [3:0]  regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [31:0] regRdata;
    logic        rOp_n, rSb_n, mOp, sKey, sOp, sSb;
    logic [8:0]  outs;
    int          miscompares = 0;
    int          checkCount = 0;

    initial begin
        forever #2.5 clk = ~clk;
    end

    tmc_panel_model far (.clk(clk), .sys_rst(sysRst), .fireOp(fireOp),
        .fireSb(fireSb), .src(src), .holdSb(holdSb), .rmtOperate_n(rOp_n),
        .rmtStandby_n(rSb_n), .menuOp(mOp), .stbKey(sKey), .serOp(sOp),
        .serSb(sSb));

    tmc_mode_ctrl uut (.clk(clk), .sys_rst(sysRst), .rmtOperate_n(rOp_n),
        .rmtStandby_n(rSb_n), .operate_menu_selection(mOp),
        .standby_menu_key(sKey), .serialOperateCmd(sOp),
        .serialStandbyCmd(sSb), .heatSinkTempC(temp), .ampInterlock(amp),
        .upconvUnlocked(muteV[0]), .upconvAbsent(muteV[1]),
        .ifStageAbsent(muteV[2]), .modulatorMute(muteV[3]),
        .otherFault(fault), .inputPresent(inPres), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .ifEnable(outs[8]), .ifMute(outs[7]),
        .supplyEnable(outs[6]), .powerCutback(outs[5]),
        .ledOperate(outs[4]), .ledMuteRed(outs[3]), .ledAmpEnable(outs[2]),
        .ledInputFault(outs[1]), .rmtStateOut_n(outs[0]));

    task automatic wrapUp();
        $display("checks %0d mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chkOut(logic [8:0] exp);
        checkCount++;
        if (outs !== exp) begin
            miscompares++;
            $display("wrong value at %0t: outputs %h, expected %h",
                $time, outs, exp);
        end
    endtask

    task automatic chkRead(logic [3:0] a, logic [31:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        checkCount++;
        if (regRdata !== exp) begin
            miscompares++;
            $display("wrong value at %0t: read %h, expected %h",
                $time, regRdata, exp);
        end
    endtask

    task automatic regWrite(logic [3:0] a, logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic req(logic op, logic sb, logic [1:0] s);
        @(posedge clk);
        src <= s;
        fireOp <= op;
        fireSb <= sb;
        @(posedge clk);
        fireOp <= 1'b0;
        fireSb <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
    endtask

    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        wrapUp();
    end

    initial begin
        repeat (20) @(posedge clk);
        sysRst <= 1'b0;
        settle();
        chkOut(STBY);
        for (int s = 0; s < 3; s++) begin
            req(1'b1, 1'b0, s[1:0]);
            chkOut(OPER);
            req(1'b0, 1'b1, s[1:0]);
            chkOut(STBY);
        end
        req(1'b1, 1'b1, 2'h2);
        chkOut(STBY);
        $display("test requests done");
        for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            temp <= (k == 0) ? 8'h4F : 8'h4E;
            muteV <= (k == 1) ? 4'h8 : 4'h0;
            amp <= (k == 2);
            holdSb <= (k == 3);
            fault <= (k == 4);
            req(1'b1, 1'b0, 2'h2);
            chkOut(STBY);
        end
        @(posedge clk);
        fault <= 1'b0;
        req(1'b1, 1'b0, 2'h1);
        chkOut(OPER);
        $display("test interlocks done");
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            muteV <= 4'(1 << m);
            settle();
            chkOut(MUTD);
            @(posedge clk);
            muteV <= 4'h0;
            settle();
            chkOut(OPER);
        end
        @(posedge clk);
        inPres <= 1'b0;
        settle();
        chkOut(CUTB);
        @(posedge clk);
        inPres <= 1'b1;
        settle();
        chkOut(OPER);
        req(1'b0, 1'b1, 2'h0);
        chkOut(STBY);
        $display("test mute and input done");
        chkRead(tmc_pkg::ADDR_FREQ, 32'h0000_01D6);
        regWrite(tmc_pkg::ADDR_CHANNEL, 32'h0000_0053);
        chkRead(tmc_pkg::ADDR_FREQ, 32'h0000_0374);
        regWrite(tmc_pkg::ADDR_CHANNEL, 32'h0000_0054);
        chkRead(tmc_pkg::ADDR_CHANNEL, 32'h0000_0053);
        regWrite(tmc_pkg::ADDR_CHANNEL, 32'h0000_0020);
        chkRead(tmc_pkg::ADDR_FREQ, 32'h0000_0242);
        regWrite(tmc_pkg::ADDR_CUSTOM, 32'h0000_0300);
        regWrite(tmc_pkg::ADDR_CTRL, 32'h0000_0004);
        chkRead(tmc_pkg::ADDR_FREQ, 32'h0000_0300);
        chkRead(tmc_pkg::ADDR_CUSTOM, 32'h0000_0300);
        chkRead(tmc_pkg::ADDR_CTRL, 32'h0000_0004);
        chkRead(4'hF, 32'h0000_0000);
        $display("test frequency done");
        regWrite(tmc_pkg::ADDR_CTRL, 32'h0000_0001);
        chkRead(tmc_pkg::ADDR_STATUS, 32'h0000_0042);
        chkOut(OPER);
        regWrite(tmc_pkg::ADDR_CTRL, 32'h0000_0002);
        settle();
        chkOut(STBY);
        @(posedge clk);
        temp <= 8'h4F;
        chkRead(tmc_pkg::ADDR_STATUS, 32'h0000_00C9);
        $display("test software control done");
        wrapUp();
    end
endmodule
